// File: design/accumulator_add_datapath.v
/*
  Addition group datapath of an 8-bit core: accumulator, status flags and
  the write-back of sums to the accumulator or to data memory.
  Assumes the decoder presents one operation per start pulse with the memory
  operand already read, and that the memory port accepts the write strobe.
*/
// How it works
// - Add-with-carry-to-accumulator sums accumulator, memory byte and carry into the accumulator.
// - Add-with-carry-to-memory writes accumulator plus memory byte plus carry back to memory.
// - Plain add-memory sums accumulator and memory byte without carry into the accumulator.
// - Add-immediate sums accumulator and the immediate byte without carry into the accumulator.
// - Add-to-memory writes accumulator plus memory byte into memory, accumulator kept.
// - Every addition updates overflow, zero, auxiliary carry and carry from the sum.
`timescale 1ns/1ps
`include "accumulator_add_regs.vh"

module accumulator_add_datapath (
  input wire CORE_CLK_I,
  input wire RST_I,
  input wire START_I,
  input wire [2:0] OP_I,
  input wire [7:0] MEM_DATA_I,
  input wire [7:0] IMM_I,
  output reg [7:0] ACC_O,
  output reg [3:0] FLAGS_O,
  output reg [7:0] MEM_WDATA_O,
  output reg MEM_WE_O,
  output reg DONE_O
);

  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_ADD = 2'b01;
  localparam [1:0] ST_WRITE = 2'b10;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [2:0] op_reg;
  reg [2:0] op_next;
  reg [7:0] a_reg;
  reg [7:0] a_next;
  reg [7:0] b_reg;
  reg [7:0] b_next;
  reg cin_reg;
  reg cin_next;
  reg [7:0] acc_next;
  reg [7:0] wdata_next;
  reg we_next;
  reg done_next;
  wire [3:0] flags_next;
  wire [7:0] operand;
  wire [7:0] sum;
  wire [3:0] flags;
  wire take;
  wire write_back;

  genvar i;

  function is_valid_op;
    input [2:0] op;
    begin
      is_valid_op = (op == `OP_SUM_WITH_CARRY_TO_ACC) ||
                    (op == `OP_SUM_WITH_CARRY_TO_MEMORY) ||
                    (op == `OP_SUM_TO_ACC) ||
                    (op == `OP_SUM_IMMEDIATE) ||
                    (op == `OP_SUM_TO_MEMORY);
    end
  endfunction

  function uses_carry;
    input [2:0] op;
    begin
      uses_carry = (op == `OP_SUM_WITH_CARRY_TO_ACC) ||
                   (op == `OP_SUM_WITH_CARRY_TO_MEMORY);
    end
  endfunction

  function uses_immediate;
    input [2:0] op;
    begin
      uses_immediate = (op == `OP_SUM_IMMEDIATE);
    end
  endfunction

  function is_to_memory;
    input [2:0] op;
    begin
      is_to_memory = (op == `OP_SUM_WITH_CARRY_TO_MEMORY) ||
                     (op == `OP_SUM_TO_MEMORY);
    end
  endfunction

  // A start while busy or with an unused code is dropped without a trace, so
  // the decoder must space its starts three cycles apart.
  assign take = START_I && is_valid_op(OP_I) && (state_reg == ST_IDLE);
  assign write_back = (state_reg == ST_WRITE);

  byte_adder u_adder (
    .clk_i(CORE_CLK_I),
    .rst_i(RST_I),
    .a_i(a_reg),
    .b_i(b_reg),
    .cin_i(cin_reg),
    .sum_o(sum),
    .flags_o(flags)
  );

  generate
    for (i = 0; i < 8; i = i + 1) begin : g_operand
      assign operand[i] = uses_immediate(OP_I) ? IMM_I[i] : MEM_DATA_I[i];
    end
  endgenerate

  generate
    for (i = 0; i < 4; i = i + 1) begin : g_flag
      assign flags_next[i] = write_back ? flags[i] : FLAGS_O[i];
    end
  endgenerate

  always @* begin
    state_next = state_reg;
    op_next = op_reg;
    a_next = a_reg;
    b_next = b_reg;
    cin_next = cin_reg;
    case (state_reg)
      ST_IDLE: begin
        if (take) begin
          op_next = OP_I;
          a_next = ACC_O;
          b_next = operand;
          cin_next = uses_carry(OP_I) ? FLAGS_O[`FLAG_C] : 1'b0;
          state_next = ST_ADD;
        end
      end
      ST_ADD: begin
        // The adder registers its result, so one cycle passes before write-back.
        state_next = ST_WRITE;
      end
      ST_WRITE: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @* begin
    acc_next = ACC_O;
    wdata_next = MEM_WDATA_O;
    we_next = 1'b0;
    done_next = 1'b0;
    if (write_back) begin
      done_next = 1'b1;
      if (is_to_memory(op_reg)) begin
        wdata_next = sum;
        we_next = 1'b1;
      end else begin
        acc_next = sum;
      end
    end
  end

  always @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      op_reg <= `OP_NONE;
    end else begin
      op_reg <= op_next;
    end
  end

  always @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      a_reg <= `OPERAND_RESET;
    end else begin
      a_reg <= a_next;
    end
  end

  always @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      b_reg <= `OPERAND_RESET;
    end else begin
      b_reg <= b_next;
    end
  end

  always @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      cin_reg <= `CIN_RESET;
    end else begin
      cin_reg <= cin_next;
    end
  end

  always @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      ACC_O <= `ACC_RESET;
    end else begin
      ACC_O <= acc_next;
    end
  end

  always @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      FLAGS_O <= `FLAGS_RESET;
    end else begin
      FLAGS_O <= flags_next;
    end
  end

  // Write data hold their last value so a slow memory port may latch late.
  always @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      MEM_WDATA_O <= `WDATA_RESET;
    end else begin
      MEM_WDATA_O <= wdata_next;
    end
  end

  always @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      MEM_WE_O <= `STROBE_RESET;
    end else begin
      MEM_WE_O <= we_next;
    end
  end

  always @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      DONE_O <= `STROBE_RESET;
    end else begin
      DONE_O <= done_next;
    end
  end

endmodule

// File: design/accumulator_add_regs.vh
/*
  Constants for the accumulator addition datapath: operation codes, flag bit
  positions and reset values.
  Assumes inclusion by bare name from the datapath files.
*/
`ifndef ACCUMULATOR_ADD_REGS_VH
`define ACCUMULATOR_ADD_REGS_VH

`define OP_NONE 3'h0
`define OP_SUM_WITH_CARRY_TO_ACC 3'h1
`define OP_SUM_WITH_CARRY_TO_MEMORY 3'h2
`define OP_SUM_TO_ACC 3'h3
`define OP_SUM_IMMEDIATE 3'h4
`define OP_SUM_TO_MEMORY 3'h5

`define FLAG_C 0
`define FLAG_AC 1
`define FLAG_Z 2
`define FLAG_OV 3

`define ACC_RESET 8'h00
`define FLAGS_RESET 4'h0
`define OPERAND_RESET 8'h00
`define SUM_RESET 8'h00
`define WDATA_RESET 8'h00
`define CIN_RESET 1'b0
`define STROBE_RESET 1'b0

`endif

// File: design/byte_adder.v
/*
  Registered 8-bit adder with carry in, producing the sum and the four
  status flags one clock after the operands are presented.
  Assumes operands are stable and on the core clock.
*/
`timescale 1ns/1ps
`include "accumulator_add_regs.vh"

module byte_adder (
  input wire clk_i,
  input wire rst_i,
  input wire [7:0] a_i,
  input wire [7:0] b_i,
  input wire cin_i,
  output reg [7:0] sum_o,
  output reg [3:0] flags_o
);

  wire [4:0] low_sum;
  wire [8:0] full_sum;
  wire [7:0] res;

  assign low_sum = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin_i};
  assign full_sum = {1'b0, a_i} + {1'b0, b_i} + {8'h00, cin_i};
  assign res = full_sum[7:0];

  always @(posedge clk_i) begin
    if (rst_i) begin
      sum_o <= `SUM_RESET;
      flags_o <= `FLAGS_RESET;
    end else begin
      sum_o <= res;
      flags_o[`FLAG_C] <= full_sum[8];
      flags_o[`FLAG_AC] <= low_sum[4];
      flags_o[`FLAG_Z] <= (res == 8'h00);
      flags_o[`FLAG_OV] <= (a_i[7] == b_i[7]) && (res[7] != a_i[7]);
    end
  end

endmodule

// File: dv/acc_add_chk.sv
/*
  Property checker for the addition datapath, watching only its ports.
  Assumes one core clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module acc_add_chk (
  input wire CORE_CLK_I,
  input wire RST_I,
  input wire START_I,
  input wire [2:0] OP_I,
  input wire [7:0] MEM_DATA_I,
  input wire [7:0] IMM_I,
  input wire [7:0] ACC_O,
  input wire [3:0] FLAGS_O,
  input wire [7:0] MEM_WDATA_O,
  input wire MEM_WE_O,
  input wire DONE_O
);
  reg [1:0] busy_reg;
  wire [7:0] b = (OP_I == 3'h4) ? IMM_I : MEM_DATA_I;
  wire ci = ((OP_I == 3'h1) || (OP_I == 3'h2)) & FLAGS_O[0];
  wire [8:0] s = {1'b0, ACC_O} + {1'b0, b} + {8'h00, ci};
  wire [4:0] h = {1'b0, ACC_O[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
  wire v = (ACC_O[7] == b[7]) & (s[7] != ACC_O[7]);
  wire go = START_I & (OP_I != 3'h0) & (OP_I < 3'h6);
  wire taken = go & (busy_reg == 2'h0);
  wire mo = (OP_I == 3'h2) | (OP_I == 3'h5);
  // A taken start keeps the datapath busy for the next two edges.
  always @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      busy_reg <= 2'h0;
    end else if (taken) begin
      busy_reg <= 2'h2;
    end else if (busy_reg != 2'h0) begin
      busy_reg <= busy_reg - 2'h1;
    end
  end
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);
  a_acc_carry_sum: assert property (taken && OP_I == 3'h1 |-> ##3 ACC_O == $past(s[7:0], 3))
    else $error("adc to acc wrong");
  a_acc_plain_sum: assert property (taken && !mo && OP_I != 3'h1 |->
    ##3 ACC_O == $past(s[7:0], 3))
    else $error("add to acc wrong");
  a_mem_write_back: assert property (taken && mo |->
    ##3 MEM_WE_O && MEM_WDATA_O == $past(s[7:0], 3))
    else $error("memory write wrong");
  a_mem_keeps_acc: assert property (taken && mo |-> ##3 ACC_O == $past(ACC_O, 3))
    else $error("acc changed on memory op");
  a_done_one_pulse: assert property (taken |-> ##3 DONE_O ##1 (!DONE_O && !MEM_WE_O))
    else $error("done pulse wrong");
  a_carry_flags: assert property (taken |-> ##3 FLAGS_O[1:0] == $past({h[4], s[8]}, 3))
    else $error("carry flags wrong");
  a_zero_ov_flags: assert property (taken |->
    ##3 FLAGS_O[3:2] == $past({v, s[7:0] == 8'h00}, 3))
    else $error("zero or overflow wrong");
  a_no_stray_write: assert property ((DONE_O || MEM_WE_O) |-> $past(taken, 3))
    else $error("done or write without a taken start");
  c_mem_op: cover property (taken && mo);
  c_carry_in: cover property (taken && ci);
  c_overflow: cover property (taken && v);
  c_busy_start: cover property (go && !taken);
endmodule
bind accumulator_add_datapath acc_add_chk i_chk (
  .CORE_CLK_I(CORE_CLK_I),
  .RST_I(RST_I),
  .START_I(START_I),
  .OP_I(OP_I),
  .MEM_DATA_I(MEM_DATA_I),
  .IMM_I(IMM_I),
  .ACC_O(ACC_O),
  .FLAGS_O(FLAGS_O),
  .MEM_WDATA_O(MEM_WDATA_O),
  .MEM_WE_O(MEM_WE_O),
  .DONE_O(DONE_O)
);

// File: dv/tb_top.sv
/* Directed bench for the addition datapath. Assumes one clock and a synchronous reset. */
`timescale 1ns/1ps
module tb_top;
  reg clk = 0, rst = 1, st = 0;
  reg [2:0] op = 0;
  reg [7:0] md = 0, im = 0;
  wire [7:0] acc, wd;
  wire [3:0] fl;
  wire we, dn;
  integer n_errors = 0, n_checks = 0;
  accumulator_add_datapath i_dut(.CORE_CLK_I(clk), .RST_I(rst), .START_I(st), .OP_I(op),
    .MEM_DATA_I(md), .IMM_I(im), .ACC_O(acc), .FLAGS_O(fl), .MEM_WDATA_O(wd),
    .MEM_WE_O(we), .DONE_O(dn));
  initial forever #2 clk = ~clk;
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  task chk(input [47:0] nm, input [7:0] s, input [7:0] e);
    begin
      n_checks = n_checks + 1;
      if (s !== e) begin
        n_errors = n_errors + 1;
        $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  task run(input [2:0] o, input [7:0] m, input [7:0] ea, input [3:0] ef, input [7:0] ew);
    integer k;
    begin
      @(posedge clk);
      st <= 1;
      op <= o;
      md <= (o == 3'h4) ? ~m : m;
      im <= (o == 3'h4) ? m : ~m;
      @(posedge clk);
      st <= 0;
      #1;
      k = 0;
      while (dn !== 1'b1 && k < 5) begin
        @(posedge clk);
        #1;
        k = k + 1;
      end
      if (dn !== 1'b1) begin
        n_errors = n_errors + 1;
        end_of_test;
      end else begin
        chk("acc", acc, ea);
        chk("flags", {4'h0, fl}, {4'h0, ef});
        chk("we", {7'h00, we}, {7'h00, o == 3'h2 || o == 3'h5});
        chk("wdata", wd, ew);
      end
    end
  endtask
  task quiet(input integer n);
    integer j;
    begin
      for (j = 0; j < n; j = j + 1) begin
        @(posedge clk);
        #1;
        chk("done", {7'h00, dn}, 8'h00);
        chk("we", {7'h00, we}, 8'h00);
      end
    end
  endtask
  task refuse(input [2:0] o);
    begin
      @(posedge clk);
      st <= 1;
      op <= o;
      md <= 8'h11;
      im <= 8'h11;
      @(posedge clk);
      st <= 0;
      quiet(3);
      chk("acc", acc, 8'h00);
      chk("flags", {4'h0, fl}, 8'h00);
    end
  endtask
  task t_acc;
    begin
      run(3'h4, 8'h7F, 8'h7F, 4'h0, 8'h00);
      run(3'h3, 8'h01, 8'h80, 4'hA, 8'h00);
      run(3'h1, 8'h80, 8'h00, 4'hD, 8'h00);
      run(3'h1, 8'h01, 8'h02, 4'h0, 8'h00);
      $display("accumulator test done");
    end
  endtask
  task t_mem;
    begin
      run(3'h5, 8'hFF, 8'h02, 4'h3, 8'h01);
      run(3'h4, 8'h00, 8'h02, 4'h0, 8'h01);
      run(3'h5, 8'hFF, 8'h02, 4'h3, 8'h01);
      run(3'h2, 8'h00, 8'h02, 4'h0, 8'h03);
      $display("memory test done");
    end
  endtask
  task t_reset;
    begin
      @(posedge clk);
      st <= 1;
      op <= 3'h4;
      im <= 8'h33;
      md <= 8'hCC;
      @(posedge clk);
      st <= 0;
      rst <= 1;
      repeat (2) @(posedge clk);
      rst <= 0;
      #1;
      chk("acc", acc, 8'h00);
      chk("flags", {4'h0, fl}, 8'h00);
      chk("wdata", wd, 8'h00);
      quiet(3);
      chk("acc", acc, 8'h00);
      $display("reset test done");
    end
  endtask
  task t_refuse;
    begin
      refuse(3'h0);
      refuse(3'h6);
      refuse(3'h7);
      @(posedge clk);
      st <= 1;
      op <= 3'h3;
      md <= 8'h01;
      im <= 8'hFE;
      @(posedge clk);
      op <= 3'h4;
      im <= 8'h40;
      repeat (2) @(posedge clk);
      st <= 0;
      #1;
      chk("done", {7'h00, dn}, 8'h01);
      chk("acc", acc, 8'h01);
      chk("flags", {4'h0, fl}, 8'h00);
      quiet(3);
      chk("acc", acc, 8'h01);
      $display("refusal test done");
    end
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 0;
    t_acc;
    t_mem;
    t_reset;
    t_refuse;
    end_of_test;
  end
endmodule
